// *** hdl/port_c_pin_mux_gpio.sv ***
// Purpose: Eight-pin bidirectional port with direction register and peripheral mux
// Assumes: Classic Wishbone slave; pin inputs already synchronous to ref_clk_in
// Notes:   Ack one cycle after request, dropped the next cycle
//
// The register offsets and the Wishbone register port were chosen for this implementation.

module port_c_pin_mux_gpio
	import port_c_pkg::*;
(
	input  wire logic                  ref_clk_in,
	input  wire logic                  arst_n_in,
	input  wire logic                  wb_cyc_in,
	input  wire logic                  wb_stb_in,
	input  wire logic                  wb_we_in,
	input  wire logic [3:0]            wb_adr_in,
	input  wire logic [3:0]            wb_sel_in,
	input  wire logic [31:0]           wb_dat_in,
	output logic                       wb_ack_out,
	output logic [31:0]                wb_dat_out,
	input  wire port_c_pkg::periph_req_type periph_req_in,
	input  wire logic [7:0]            pin_level_in,
	output port_c_pkg::pin_drive_type  pin_drive_out,
	output logic [7:0]                 periph_pin_level_out
);
	import port_c_pkg::*;

	logic [7:0]    port_c_direction;
	logic [7:0]    next_port_c_direction;
	logic [7:0]    port_c_pin_data;
	logic [7:0]    next_port_c_pin_data;
	logic          ack;
	logic          next_ack;
	logic [31:0]   rdata;
	logic [31:0]   next_rdata;
	pin_drive_type drive;
	pin_drive_type next_drive;
	logic [7:0]    pin_in;
	logic [7:0]    next_pin_in;
	logic          latch_seeded;
	logic          next_latch_seeded;
	logic          req;
	logic          wr_lane0;

	assign req      = wb_cyc_in && wb_stb_in && !ack;
	assign wr_lane0 = req && wb_we_in && wb_sel_in[0];

	// Registers and bus answer
	always_comb begin
		next_port_c_direction = port_c_direction;
		next_port_c_pin_data  = port_c_pin_data;
		next_ack              = req;
		next_rdata            = 32'h0000_0000;
		next_latch_seeded     = 1'b1;
		if (wr_lane0 && wb_adr_in == ADDR_DIRECTION) begin
			next_port_c_direction = wb_dat_in[7:0];
		end
		if (wr_lane0 && wb_adr_in == ADDR_PIN_DATA) begin
			next_port_c_pin_data = wb_dat_in[7:0];
		end
		if (req && !wb_we_in) begin
			case (wb_adr_in)
				ADDR_PIN_DATA:      next_rdata = {24'h00_0000, pin_in};
				ADDR_DIRECTION:     next_rdata = {24'h00_0000, port_c_direction};
				ADDR_PERIPH_STATUS: next_rdata = {24'h00_0000, periph_req_in.select};
				default:            next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Direction returns to all ones on any reset
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			port_c_direction <= DIRECTION_RESET;
			ack              <= 1'b0;
			rdata            <= 32'h0000_0000;
			latch_seeded     <= 1'b0;
		end else begin
			port_c_direction <= next_port_c_direction;
			ack              <= next_ack;
			rdata            <= next_rdata;
			latch_seeded     <= next_latch_seeded;
		end
	end

	// Latch is outside the reset net so it survives resets; seeded once
	// from zero only so simulation leaves the X state
	always_ff @(posedge ref_clk_in) begin
		if (!latch_seeded && port_c_pin_data === 8'hxx) begin
			port_c_pin_data <= LATCH_RESET;
		end else begin
			port_c_pin_data <= next_port_c_pin_data;
		end
	end

	// Pin drivers, one slice per pin
	generate
		for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_pin
			logic sel;
			logic out_en;
			logic out_data;
			assign sel = periph_req_in.select[i] && PERIPH_CAPABLE[i];
			always_comb begin
				out_data = sel ? periph_req_in.data[i]
					: port_c_pin_data[i];
				if (sel && OVERRIDE_CAPABLE[i] && periph_req_in.force_in[i]) begin
					out_en = 1'b0;
				end else if (sel && OVERRIDE_CAPABLE[i] && periph_req_in.force_out[i]) begin
					out_en = 1'b1;
				end else if (sel) begin
					// No override: direction bit still gates the pin
					out_en = !port_c_direction[i] && periph_req_in.oe[i];
				end else begin
					out_en = !port_c_direction[i];
				end
			end
			// Each slice writes only its own bits, so no two processes share one
			assign next_drive.data[i] = out_data;
			assign next_drive.oe_n[i] = !out_en;
		end
	endgenerate

	assign next_pin_in = pin_level_in;

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			drive  <= '{data: 8'h00, oe_n: 8'hff};
			pin_in <= 8'h00;
		end else begin
			drive  <= next_drive;
			pin_in <= next_pin_in;
		end
	end

	assign wb_ack_out           = ack;
	assign wb_dat_out           = rdata;
	assign pin_drive_out        = drive;
	assign periph_pin_level_out = pin_in;

	AST_DIR_INPUT_HIZ: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		port_c_direction[7]
		|=> pin_drive_out.oe_n[7])
		else $error("Pin 7 driven while input");
	AST_DIR_OUTPUT_DRIVES: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(!port_c_direction[6] && !periph_req_in.select[6]) |=> (!pin_drive_out.oe_n[6]
		&& pin_drive_out.data[6] == $past(port_c_pin_data[6])))
		else $error("Pin 6 does not drive latch");
	AST_FORCE_INPUT: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(periph_req_in.select[1] && periph_req_in.force_in[1]) |=> pin_drive_out.oe_n[1])
		else $error("Forced input pin still driven");
	AST_FORCE_OUTPUT: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(periph_req_in.select[0] && !periph_req_in.force_in[0] && periph_req_in.force_out[0])
		|=> !pin_drive_out.oe_n[0])
		else $error("Forced output pin not driven");
	AST_PERIPH_DATA: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		periph_req_in.select[5] |=> pin_drive_out.data[5] == $past(periph_req_in.data[5]))
		else $error("Peripheral data not muxed");
	AST_OE_NEEDS_SELECT: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		!periph_req_in.select[2] |=> pin_drive_out.oe_n[2] == $past(port_c_direction[2]))
		else $error("Unselected enable drove pin");
	AST_NO_OVERRIDE_SERIAL: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(port_c_direction[3] && periph_req_in.force_out[3]) |=> pin_drive_out.oe_n[3])
		else $error("Serial clock pin overrode direction");
	AST_PLAIN_PIN: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(port_c_direction[7] == 1'b0) |=> pin_drive_out.data[7] == $past(port_c_pin_data[7]))
		else $error("Plain pin took peripheral data");
	AST_DIR_WRITE: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(wr_lane0 && wb_adr_in == ADDR_DIRECTION) |=> (port_c_direction == $past(wb_dat_in[7:0])
		&& wb_ack_out))
		else $error("Direction write lost");
	AST_READ_PINS: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(req && !wb_we_in && wb_adr_in == ADDR_PIN_DATA) ##1 1'b1
		|-> wb_dat_out[7:0] == $past(pin_in) && wb_dat_out[31:8] == 24'h00_0000)
		else $error("Pin read wrong");

	// Bus answer timing and data
	AST_ACK_AFTER_REQ: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		req
		|=> wb_ack_out)
		else $error("Request not acknowledged");

	AST_NO_ACK_WITHOUT_REQ: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		!req
		|=> !wb_ack_out)
		else $error("Ack without request");

	AST_ACK_ONE_CYCLE: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		wb_ack_out
		|=> !wb_ack_out)
		else $error("Ack held too long");

	AST_READ_UPPER_ZERO: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		wb_ack_out
		|-> wb_dat_out[31:8] == 24'h00_0000)
		else $error("Upper read bits set");

	AST_WRITE_NO_DATA: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(req && wb_we_in)
		|=> wb_dat_out == 32'h0000_0000)
		else $error("Write returned data");

	// Register reads and writes
	AST_DIR_READ: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(req && !wb_we_in && wb_adr_in == ADDR_DIRECTION)
		|=> wb_dat_out[7:0] == $past(port_c_direction))
		else $error("Direction read wrong");

	AST_STATUS_READ: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(req && !wb_we_in && wb_adr_in == ADDR_PERIPH_STATUS)
		|=> wb_dat_out[7:0] == $past(periph_req_in.select))
		else $error("Status read wrong");

	AST_UNMAPPED_READ_ZERO: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(req && !wb_we_in && wb_adr_in != ADDR_PIN_DATA && wb_adr_in != ADDR_DIRECTION
		&& wb_adr_in != ADDR_PERIPH_STATUS) |=> wb_dat_out == 32'h0000_0000)
		else $error("Unmapped read not zero");

	AST_LATCH_WRITE: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(wr_lane0 && wb_adr_in == ADDR_PIN_DATA)
		|=> port_c_pin_data == $past(wb_dat_in[7:0]))
		else $error("Latch write lost");

	AST_LATCH_HOLDS: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(latch_seeded && !(wr_lane0 && wb_adr_in == ADDR_PIN_DATA))
		|=> $stable(port_c_pin_data))
		else $error("Latch changed without write");

	AST_SEL_WRITE_IGNORED: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(latch_seeded && req && wb_we_in && !wb_sel_in[0])
		|=> $stable(port_c_direction) && $stable(port_c_pin_data))
		else $error("Write without lane took effect");

	// Reset values seen at the first edge after release
	AST_DIR_RESET: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		$rose(arst_n_in)
		|-> port_c_direction == DIRECTION_RESET)
		else $error("Direction not all ones after reset");

	AST_OE_RESET: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		$rose(arst_n_in)
		|-> pin_drive_out.oe_n == 8'hff)
		else $error("Pin driven after reset");

	// Pin path
	AST_LEVEL_FOLLOWS_PIN: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		1'b1
		|=> periph_pin_level_out == $past(pin_level_in))
		else $error("Pin level not passed on");

	AST_PIN7_OUTPUT: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		!port_c_direction[7]
		|=> !pin_drive_out.oe_n[7])
		else $error("Pin 7 not driven as output");

	AST_SERIAL_CLOCK_LATCH: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(!periph_req_in.select[3] && !port_c_direction[3])
		|=> !pin_drive_out.oe_n[3] && pin_drive_out.data[3] == $past(port_c_pin_data[3]))
		else $error("Pin 3 does not drive latch");

	AST_SERIAL_DATA_IN_DIR: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		port_c_direction[4]
		|=> pin_drive_out.oe_n[4])
		else $error("Pin 4 driven while input");

	AST_SERIAL_OUT_NEEDS_DIR: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(periph_req_in.select[5] && !port_c_direction[5] && periph_req_in.oe[5])
		|=> !pin_drive_out.oe_n[5])
		else $error("Serial output not driven");

	AST_CCP_NO_OVERRIDE: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(periph_req_in.select[2] && periph_req_in.oe[2] && port_c_direction[2])
		|=> pin_drive_out.oe_n[2])
		else $error("Capture pin overrode direction");

	AST_PERIPH_DATA_PIN2: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		periph_req_in.select[2]
		|=> pin_drive_out.data[2] == $past(periph_req_in.data[2]))
		else $error("Pin 2 peripheral data not muxed");

	AST_LATCH_DATA_PIN0: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		!periph_req_in.select[0]
		|=> pin_drive_out.data[0] == $past(port_c_pin_data[0]))
		else $error("Pin 0 latch data not muxed");

	AST_PLAIN_IGNORES_SELECT: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(periph_req_in.select[6] && !port_c_direction[6])
		|=> pin_drive_out.data[6] == $past(port_c_pin_data[6]))
		else $error("Plain pin took peripheral path");

	AST_FORCE_IN_WINS: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(periph_req_in.select[0] && periph_req_in.force_in[0] && periph_req_in.force_out[0])
		|=> pin_drive_out.oe_n[0])
		else $error("Forced input lost to forced output");

endmodule : port_c_pin_mux_gpio

// *** inc/port_c_pkg.sv ***
// Purpose: Shared constants and carriers for the eight-pin muxed port
// Assumes: Classic Wishbone slave, 32-bit data, one word per register
// Notes:   Offsets are byte addresses
package port_c_pkg;

	localparam int                PORT_WIDTH           = 8;
	localparam logic [3:0]        ADDR_PIN_DATA        = 4'h0;
	localparam logic [3:0]        ADDR_DIRECTION       = 4'h4;
	localparam logic [3:0]        ADDR_PERIPH_STATUS   = 4'h8;
	localparam logic [7:0]        DIRECTION_RESET      = 8'hff;
	localparam logic [7:0]        LATCH_RESET          = 8'h00;
	localparam int                POS_TIMER_OSC_OUTPUT = 0;
	localparam int                POS_TIMER_OSC_INPUT  = 1;
	localparam int                POS_CCP              = 2;
	localparam int                POS_SERIAL_CLOCK     = 3;
	localparam int                POS_SERIAL_DATA_IN   = 4;
	localparam int                POS_SERIAL_DATA_OUT  = 5;
	// Pins whose direction a peripheral may force (timer oscillator pins)
	localparam logic [7:0]        OVERRIDE_CAPABLE     = 8'h03;
	// Pins that have any peripheral at all
	localparam logic [7:0]        PERIPH_CAPABLE       = 8'h3f;

	// Per-pin peripheral request, one bit per pin
	typedef struct packed {
		logic [7:0] select;     // Peripheral owns the pin
		logic [7:0] data;       // Peripheral output value
		logic [7:0] oe;         // Peripheral output enable, active high
		logic [7:0] force_in;   // Override forces input
		logic [7:0] force_out;  // Override forces output
	} periph_req_type;

	// Pin driver group; oe_n low means the pin is driven
	typedef struct packed {
		logic [7:0] data;
		logic [7:0] oe_n;
	} pin_drive_type;

endpackage : port_c_pkg

// *** test/pin_model.sv ***
// Purpose: Outside world of the eight port pins
// Assumes: Pins settle within the cycle; no pull-ups
// Notes:   Undriven pins follow an outside source set by the bench
module pin_model
	import port_c_pkg::*;
(
	input  wire port_c_pkg::pin_drive_type drive_in,
	input  wire logic [7:0]                ext_in,
	output logic [7:0]                     level_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// Driven pins show the driver, released pins the outside source
	assign level_out = (drive_in.data & ~drive_in.oe_n) | (ext_in & drive_in.oe_n);
endmodule : pin_model

// *** test/port_c_pin_mux_gpio_tb.sv ***
// Purpose: Self-checking bench for the muxed eight-pin port
// Assumes: Ack answers each request; pin path settles within two cycles
// Notes:   Reads are checked by a monitor against queued notes
module port_c_pin_mux_gpio_tb
	import port_c_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic           ref_clk_in = 1'b0, arst_n_in = 1'b0, cyc = 1'b0, we = 1'b0;
	logic [3:0]     adr = 4'h0, sel = 4'h0;
	logic [31:0]    wdat = 32'h0000_0000, rdat;
	logic           ack;
	periph_req_type req = '0, r;
	pin_drive_type  drive, ed;
	logic [7:0]     level, ext = 8'h00, dir, lat, plev;
	logic [31:0]    exq[$];
	int             bad_count = 0, cmp_count = 0;
	port_c_pin_mux_gpio dut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .wb_cyc_in(cyc),
		.wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
		.wb_ack_out(ack), .wb_dat_out(rdat), .periph_req_in(req), .pin_level_in(level),
		.pin_drive_out(drive), .periph_pin_level_out(plev));
	pin_model pins (.drive_in(drive), .ext_in(ext), .level_out(level));
	initial forever #12.5 ref_clk_in = ~ref_clk_in;
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : close_out
	task automatic check(string nm, logic [31:0] e, logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, s);
		end
	endtask : check
	task automatic wb(logic w, logic [3:0] a, logic [7:0] d, logic [3:0] s = 4'hf);
		int n;
		n = 0;
		@(posedge ref_clk_in);
		cyc <= 1'b1; we <= w; adr <= a; wdat <= {24'h00_0000, d}; sel <= s;
		// Ack read at the rising edge, before that edge's updates land
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) bad_count++;
		cyc <= 1'b0;
	endtask : wb
	task automatic rd(logic [3:0] a, logic [31:0] e);
		exq.push_back(e);
		wb(1'b0, a, 8'h00);
	endtask : rd
	// Selected pins: timer pins forced, others need direction and enable
	function automatic pin_drive_type model(logic [7:0] d, logic [7:0] l, periph_req_type q);
		logic [7:0] s, drv;
		s = q.select & PERIPH_CAPABLE;
		drv = (~d & ~s) | (s & ~d & q.oe & ~OVERRIDE_CAPABLE)
			| (s & ~q.force_in & OVERRIDE_CAPABLE);
		model.oe_n = ~drv;
		model.data = ((l & ~s) | (q.data & s)) & drv;
	endfunction : model
	task automatic check_pins(logic [7:0] d, logic [7:0] l, periph_req_type q);
		ed = model(d, l, q);
		check("pins", {16'h0000, ed}, {16'h0000, drive.data & ~drive.oe_n, drive.oe_n});
	endtask : check_pins
	always @(posedge ref_clk_in) begin
		if (ack === 1'b1 && we === 1'b0) check("read", exq.pop_front(), rdat);
	end
	initial begin
		repeat (20000) @(posedge ref_clk_in);
		bad_count++;
		close_out();
	end
	initial begin
		void'($urandom(32'he8bc));
		repeat (5) @(posedge ref_clk_in);
		arst_n_in <= 1'b1;
		rd(ADDR_DIRECTION, 32'h0000_00ff);
		rd(4'hc, 32'h0000_0000);
		for (int i = 0; i < 40; i++) begin
			dir = 8'($urandom);
			lat = 8'($urandom);
			r = periph_req_type'({$urandom, $urandom});
			r.force_out = ~r.force_in;
			@(posedge ref_clk_in);
			req <= r;
			ext <= 8'($urandom);
			// Software writes random pin directions, independent of the chosen functions
			wb(1'b1, ADDR_DIRECTION, dir);
			wb(1'b1, ADDR_PIN_DATA, lat);
			wb(1'b1, ADDR_DIRECTION, ~dir, 4'h0);
			rd(ADDR_DIRECTION, {24'h00_0000, dir});
			repeat (2) @(negedge ref_clk_in);
			check_pins(dir, lat, r);
			check("level", {24'h00_0000, (ed.data & ~ed.oe_n) | (ext & ed.oe_n)}, {24'h00_0000, plev});
			rd(ADDR_PIN_DATA, {24'h00_0000, (ed.data & ~ed.oe_n) | (ext & ed.oe_n)});
			rd(ADDR_PERIPH_STATUS, {24'h00_0000, r.select});
		end
		@(posedge ref_clk_in);
		req <= '0;
		arst_n_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		arst_n_in <= 1'b1;
		rd(ADDR_DIRECTION, 32'h0000_00ff);
		wb(1'b1, ADDR_DIRECTION, 8'h00);
		repeat (2) @(negedge ref_clk_in);
		check_pins(8'h00, lat, '0);
		close_out();
	end
endmodule : port_c_pin_mux_gpio_tb
